// ---- spimsu_chk.sv ----
module spimsu_chk #(
	parameter int HALF = 8
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// Resolved lines
	input  wire logic sck,
	input  wire logic ss_n,
	// Drive enables
	input  wire logic dev_sck_oe,
	input  wire logic dev_mosi_oe,
	input  wire logic dev_miso_oe,
	input  wire logic dev_ss_oe,
	input  wire logic par_sck_oe,
	input  wire logic par_mosi_oe,
	input  wire logic par_miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        sck_q;
	logic [15:0] gap;

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////
	// Cycles since the last level change of the clock line
	always_ff @(posedge mclk) begin
		sck_q <= sck;
		if (!rstn || sck != sck_q)
			gap <= 16'h0001;
		else if (gap != 16'hffff)
			gap <= gap + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////
	// Two drivers on one line would fight
	AST_MISO_ONE: assert property (!(dev_miso_oe && par_miso_oe))
		else $error("two drivers on miso");
	AST_SCK_ONE: assert property (!(dev_sck_oe && par_sck_oe))
		else $error("two drivers on sck");
	AST_MOSI_ONE: assert property (!(dev_mosi_oe && par_mosi_oe))
		else $error("two drivers on mosi");
	// Margin of five cycles covers select synchronisers
	AST_DEV_DESEL: assert property (ss_n [*5] |-> !dev_miso_oe)
		else $error("deselected device drives miso");
	AST_PAR_DESEL: assert property (ss_n [*5] |-> !par_miso_oe)
		else $error("deselected partner drives miso");
	AST_SLV_PINS: assert property (dev_miso_oe |-> !dev_sck_oe && !dev_mosi_oe)
		else $error("slave drives sck or mosi");
	AST_SCK_HALF: assert property (dev_sck_oe && $past(dev_sck_oe) && sck != sck_q
		|-> gap >= HALF)
		else $error("device sck edges too close");
	AST_FALLBACK: assert property ($fell(ss_n) && !dev_ss_oe
		|-> ##[0:6] (!dev_sck_oe && !dev_mosi_oe))
		else $error("device keeps master pins under foreign select");
endmodule : spimsu_chk

// ---- spimsu_if.sv ----
interface spimsu_if;
	logic dev_sck_o;
	logic dev_sck_oe;
	logic dev_mosi_o;
	logic dev_mosi_oe;
	logic dev_miso_o;
	logic dev_miso_oe;
	logic dev_ss_o;
	logic dev_ss_oe;
	logic par_sck_o;
	logic par_sck_oe;
	logic par_mosi_o;
	logic par_mosi_oe;
	logic par_miso_o;
	logic par_miso_oe;
	logic par_ss_o;
	logic par_ss_oe;
	logic sck;
	logic mosi;
	logic miso;
	logic ss_n;

	// Undriven lines settle low, select settles high
	assign sck  = dev_sck_oe ? dev_sck_o : (par_sck_oe ? par_sck_o : 1'b0);
	assign mosi = dev_mosi_oe ? dev_mosi_o : (par_mosi_oe ? par_mosi_o : 1'b0);
	assign miso = dev_miso_oe ? dev_miso_o : (par_miso_oe ? par_miso_o : 1'b0);
	assign ss_n = dev_ss_oe ? dev_ss_o : (par_ss_oe ? par_ss_o : 1'b1);

	modport dev (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
		dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe,
		input sck, mosi, miso, ss_n);
	modport par (output par_sck_o, par_sck_oe, par_mosi_o, par_mosi_oe,
		par_miso_o, par_miso_oe, par_ss_o, par_ss_oe,
		input sck, mosi, miso, ss_n);
endinterface : spimsu_if

// ---- spimsu_partner.sv ----
module spimsu_partner
	import spimsu_pkg::*;
#(
	parameter int HALF = HALF_CYC
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// User side
	input  wire logic       be_master,
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic [7:0] tx_byte,
	input  wire logic       start,
	output logic      [7:0] rx_byte,
	output logic            rx_done,
	output logic            busy,
	// Serial pins
	spimsu_if.par           pins
);
	////////////////////////////////////////////////////////////////////
	logic       run;
	logic [7:0] div;
	logic [4:0] kcnt;
	logic       sck_q;
	logic       ss_o;
	logic [7:0] shreg;
	logic       out_bit;
	logic [2:0] bcnt;
	logic [3:0] sy1;
	logic [3:0] sy2;
	logic [3:0] sy3;
	logic       drv_m;
	logic       miso_oe;

	logic tick, edge_ev, elead, m_samp, m_shift, m_end, s_act, lead, trail;
	logic s_samp, s_shift, samp, shift, in_bit, sel_fall, fin;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sy1 <= 4'hf;
			sy2 <= 4'hf;
			sy3 <= 4'hf;
		end else begin
			sy1 <= {pins.sck, pins.mosi, pins.miso, pins.ss_n};
			sy2 <= sy1;
			sy3 <= sy2;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Tick 0 is a select-to-clock gap, ticks 1..16 are edges
	assign tick    = run && (div == 8'(HALF - 1));
	assign edge_ev = tick && kcnt != 5'h00 && kcnt != 5'h11;
	assign elead   = kcnt[0];
	assign m_samp  = edge_ev && spimsu_samp(elead, cpha);
	assign m_shift = edge_ev && !spimsu_samp(elead, cpha);
	assign m_end   = tick && kcnt == 5'h11;
	// Only one select line is driven, so one slave at a time
	assign s_act   = !be_master && !sy2[0];
	assign lead    = (sy2[3] ^ cpol) && !(sy3[3] ^ cpol);
	assign trail   = !(sy2[3] ^ cpol) && (sy3[3] ^ cpol);
	assign s_samp  = s_act && (spimsu_samp(1'b1, cpha) ? lead : trail);
	assign s_shift = s_act && (spimsu_samp(1'b1, cpha) ? trail : lead);
	assign sel_fall = !be_master && !sy2[0] && sy3[0];
	assign samp    = m_samp || s_samp;
	assign shift   = m_shift || s_shift;
	assign in_bit  = be_master ? sy2[1] : sy2[2];
	assign fin     = m_end || (s_samp && bcnt == LAST_BIT);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			run   <= 1'b0;
			div   <= 8'h00;
			kcnt  <= 5'h00;
			sck_q <= 1'b0;
			ss_o  <= 1'b1;
		end else if (!run) begin
			div   <= 8'h00;
			kcnt  <= 5'h00;
			sck_q <= cpol;
			if (start && be_master) begin
				run  <= 1'b1;
				ss_o <= 1'b0;
			end
		end else if (tick) begin
			div  <= 8'h00;
			kcnt <= kcnt + 5'h01;
			if (edge_ev) begin
				sck_q <= !sck_q;
			end
			if (m_end) begin
				run  <= 1'b0;
				ss_o <= 1'b1;
			end
		end else begin
			div <= div + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bcnt <= 3'h0;
		end else if (!run && !s_act) begin
			bcnt <= 3'h0;
		end else if (samp) begin
			bcnt <= bcnt + 3'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			shreg   <= 8'h00;
			out_bit <= 1'b0;
		end else if (start && !busy) begin
			shreg   <= tx_byte;
			out_bit <= tx_byte[7];
		end else if (samp) begin
			shreg <= {shreg[6:0], in_bit};
		end else if (shift) begin
			out_bit <= shreg[7];
		end else if (sel_fall) begin
			out_bit <= shreg[7];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rx_byte <= 8'h00;
			rx_done <= 1'b0;
			busy    <= 1'b0;
			drv_m   <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			rx_done <= fin;
			if (fin) begin
				rx_byte <= samp ? {shreg[6:0], in_bit} : shreg;
			end
			busy    <= run || start && be_master || (s_act && bcnt != 3'h0);
			drv_m   <= be_master;
			miso_oe <= !be_master && !sy2[0];
		end
	end

	assign pins.par_sck_o   = sck_q;
	assign pins.par_mosi_o  = out_bit;
	assign pins.par_miso_o  = out_bit;
	assign pins.par_ss_o    = ss_o;
	assign pins.par_sck_oe  = drv_m;
	assign pins.par_mosi_oe = drv_m;
	assign pins.par_ss_oe   = drv_m;
	assign pins.par_miso_oe = miso_oe;
endmodule : spimsu_partner

// ---- spimsu_pkg.sv ----
package spimsu_pkg;
	////////////////////////////////////////////////////////////////////
	// Register indices on the software port
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;
	localparam logic [1:0] REG_DATA = 2'h2;
	localparam logic [1:0] REG_DIR  = 2'h3;
	// Control bits
	localparam int CTRL_EN     = 0;
	localparam int CTRL_IRQ_EN = 1;
	localparam int CTRL_MASTER_SELECT_BIT   = 2;
	localparam int CTRL_CPOL   = 3;
	localparam int CTRL_CPHA   = 4;
	// Status bits
	localparam int STAT_DONE = 0;
	localparam int STAT_WRITE_COLLISION_FLAG = 1;
	localparam int STAT_BUSY = 2;
	// Direction bits, 1 = output; DIR_SS_LVL sets the select output level
	localparam int DIR_MOSI   = 0;
	localparam int DIR_MISO   = 1;
	localparam int DIR_SCK    = 2;
	localparam int DIR_SS     = 3;
	localparam int DIR_SS_LVL = 4;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DIR_RST  = 8'h00;
	////////////////////////////////////////////////////////////////////
	// Timing
	localparam int MCLK_MHZ    = 50;
	localparam int SCK_HALF_NS = 160;
	localparam int HALF_CYC    = (SCK_HALF_NS * MCLK_MHZ) / 1000;
	localparam logic [2:0] LAST_BIT  = 3'h7;
	localparam logic [3:0] LAST_EDGE = 4'hf;
	////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {ST_IDLE, ST_MRUN, ST_SSEL} spimsu_state_type;

	// Sample on leading edge when phase is 0, else on trailing edge
	function automatic logic spimsu_samp(input logic lead, input logic cpha);
		return lead ^ cpha;
	endfunction : spimsu_samp
endpackage : spimsu_pkg

// ---- spimsu_unit.sv ----
// Contract
// - Eight-bit shift register, one bit per clock
// - Both shift registers form one circular ring
// - Master clocks only while sending a word
// - Single transmit buffer, load only when idle
// - Copy received word to buffer at completion
// - Software reads buffer before next completion
// - Data register read returns receive buffer
// - Completion sets the transfer-done flag
// - Interrupt needs done, unit and global enable
// - Mode forces input pin directions
// - Master select input held high externally
// - Low select in master falls back slave
// - Fallback also sets the transfer-done flag
// - Select output in master is plain output
// - Software re-sets master bit after fallback
// - Selected slave drives MISO if configured
// - Deselected slave passive, all pins input
// - Rising select resets slave serial logic
// - Master selects one slave at a time
// - Unselected slave leaves pins undriven
// - Polarity sets idle level, phase timing
// - Phase zero: sample leading, shift trailing
// - Write while busy ignored, sets collision
module spimsu_unit
	import spimsu_pkg::*;
#(
	parameter int HALF = HALF_CYC
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Software port
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// Interrupt
	input  wire logic       gie,
	output logic            irq,
	// Serial pins
	spimsu_if.dev           pins
);
	////////////////////////////////////////////////////////////////////
	logic [7:0]       ctrl;
	logic [7:0]       dir;
	logic             done;
	logic             write_collision_flag;
	logic [7:0]       rxbuf;
	logic [7:0]       shreg;
	logic             out_bit;
	logic [2:0]       bcnt;
	logic [3:0]       ecnt;
	logic [7:0]       div;
	logic             sck_q;
	logic [3:0]       sy1;
	logic [3:0]       sy2;
	logic [3:0]       sy3;
	logic             mosi_oe;
	logic             miso_oe;
	logic             sck_oe;
	logic             ss_oe;
	logic             ss_o;
	spimsu_state_type state;

	logic en, master_select_bit, cpol, cpha, ss_in, wr_data, fault, busy, tick;
	logic m_samp, m_shift, s_act, lead, trail, s_samp, s_shift;
	logic samp, shift, in_bit, m_done, s_done, xfer_done;
	logic [7:0] rx_word;

	////////////////////////////////////////////////////////////////////
	// Two flops before any logic sees a pin
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sy1 <= 4'hf;
			sy2 <= 4'hf;
			sy3 <= 4'hf;
		end else begin
			sy1 <= {pins.sck, pins.mosi, pins.miso, pins.ss_n};
			sy2 <= sy1;
			sy3 <= sy2;
		end
	end

	assign en      = ctrl[CTRL_EN];
	assign master_select_bit    = ctrl[CTRL_MASTER_SELECT_BIT];
	assign cpol    = ctrl[CTRL_CPOL];
	assign cpha    = ctrl[CTRL_CPHA];
	assign ss_in   = sy2[0];
	assign wr_data = wr && (addr == REG_DATA);
	// Select only matters when configured as input
	assign fault   = en && master_select_bit && !dir[DIR_SS] && !ss_in;
	assign busy    = (state == ST_MRUN) || (s_act && bcnt != 3'h0);

	////////////////////////////////////////////////////////////////////
	// Edge events, master from divider, slave from synced clock
	assign tick    = (state == ST_MRUN) && (div == 8'(HALF - 1));
	assign m_samp  = tick && spimsu_samp(!ecnt[0], cpha);
	assign m_shift = tick && !spimsu_samp(!ecnt[0], cpha);
	assign m_done  = tick && (ecnt == LAST_EDGE);
	assign s_act   = (state == ST_SSEL) && !ss_in;
	assign lead    = (sy2[3] ^ cpol) && !(sy3[3] ^ cpol);
	assign trail   = !(sy2[3] ^ cpol) && (sy3[3] ^ cpol);
	assign s_samp  = s_act && (spimsu_samp(1'b1, cpha) ? lead : trail);
	assign s_shift = s_act && (spimsu_samp(1'b1, cpha) ? trail : lead);
	assign s_done  = s_samp && (bcnt == LAST_BIT);
	assign samp    = m_samp || s_samp;
	assign shift   = m_shift || s_shift;
	assign in_bit  = master_select_bit ? sy2[1] : sy2[2];
	assign xfer_done = m_done || s_done;
	assign rx_word = samp ? {shreg[6:0], in_bit} : shreg;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (en && master_select_bit && wr_data && !fault) begin
						state <= ST_MRUN;
					end else if (en && !master_select_bit && !ss_in) begin
						state <= ST_SSEL;
					end
				end
				ST_MRUN: begin
					if (fault || !en || m_done) begin
						state <= ST_IDLE;
					end
				end
				ST_SSEL: begin
					// Deselect drops partial word
					if (!en || ss_in || master_select_bit) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Divider and edge counter
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			div   <= 8'h00;
			ecnt  <= 4'h0;
			sck_q <= 1'b0;
		end else if (state != ST_MRUN) begin
			div   <= 8'h00;
			ecnt  <= 4'h0;
			sck_q <= cpol;
		end else if (tick) begin
			div   <= 8'h00;
			ecnt  <= ecnt + 4'h1;
			sck_q <= !sck_q;
		end else begin
			div   <= div + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bcnt <= 3'h0;
		end else if (state == ST_IDLE || !s_act && state == ST_SSEL) begin
			bcnt <= 3'h0;
		end else if (samp) begin
			bcnt <= bcnt + 3'h1;
		end
	end

	// Shift register and outgoing bit
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			shreg   <= 8'h00;
			out_bit <= 1'b0;
		end else if (wr_data && en && !busy) begin
			shreg   <= wdata;
			out_bit <= wdata[7];
		end else if (samp) begin
			shreg <= {shreg[6:0], in_bit};
		end else if (shift) begin
			out_bit <= shreg[7];
		end else if (state == ST_IDLE && en && !master_select_bit && !ss_in) begin
			out_bit <= shreg[7];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rxbuf <= 8'h00;
		end else if (xfer_done) begin
			rxbuf <= rx_word;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers, hardware set or clear wins over software write
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctrl <= CTRL_RST;
		end else begin
			if (wr && addr == REG_CTRL) begin
				ctrl <= wdata;
			end
			if (fault) begin
				ctrl[CTRL_MASTER_SELECT_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			dir <= DIR_RST;
		end else if (wr && addr == REG_DIR) begin
			dir <= wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			done <= 1'b0;
			write_collision_flag <= 1'b0;
		end else begin
			if (xfer_done || fault) begin
				done <= 1'b1;
			end else if (wr && addr == REG_STAT && wdata[STAT_DONE]) begin
				done <= 1'b0;
			end
			if (wr_data && en && busy) begin
				write_collision_flag <= 1'b1;
			end else if (wr && addr == REG_STAT && wdata[STAT_WRITE_COLLISION_FLAG]) begin
				write_collision_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= done && ctrl[CTRL_IRQ_EN] && gie;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				REG_CTRL: rdata <= ctrl;
				REG_STAT: rdata <= {5'h00, busy, write_collision_flag, done};
				REG_DATA: rdata <= rxbuf;
				REG_DIR:  rdata <= dir;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin drivers; inputs are forced, outputs left to software
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mosi_oe <= 1'b0;
			miso_oe <= 1'b0;
			sck_oe  <= 1'b0;
			ss_oe   <= 1'b0;
			ss_o    <= 1'b1;
		end else begin
			mosi_oe <= en && master_select_bit && !fault && dir[DIR_MOSI];
			sck_oe  <= en && master_select_bit && !fault && dir[DIR_SCK];
			ss_oe   <= en && master_select_bit && dir[DIR_SS];
			ss_o    <= dir[DIR_SS_LVL];
			miso_oe <= en && !master_select_bit && !ss_in && dir[DIR_MISO];
		end
	end

	assign pins.dev_mosi_o  = out_bit;
	assign pins.dev_miso_o  = out_bit;
	assign pins.dev_sck_o   = sck_q;
	assign pins.dev_ss_o    = ss_o;
	assign pins.dev_mosi_oe = mosi_oe;
	assign pins.dev_miso_oe = miso_oe;
	assign pins.dev_sck_oe  = sck_oe;
	assign pins.dev_ss_oe   = ss_oe;
endmodule : spimsu_unit

// ---- test_spi_master_slave_unit.sv ----
module test_spi_master_slave_unit
	import spimsu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 8;
	logic       mclk;
	logic       rstn;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       gie;
	logic       irq;
	logic       be_master;
	logic       cpol;
	logic       cpha;
	logic [7:0] tx_byte;
	logic       start;
	logic [7:0] rx_byte;
	logic       rx_done;
	int         mismatches;
	int         checks_done;
	int         cycles;

	spimsu_if spimsu_if_i ();
	spimsu_unit #(.HALF(HALF)) spimsu_unit_i (
		.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .gie(gie), .irq(irq), .pins(spimsu_if_i));
	spimsu_partner #(.HALF(HALF)) spimsu_partner_i (
		.mclk(mclk), .rstn(rstn), .be_master(be_master), .cpol(cpol), .cpha(cpha),
		.tx_byte(tx_byte), .start(start), .rx_byte(rx_byte), .rx_done(rx_done),
		.busy(), .pins(spimsu_if_i));
	spimsu_chk #(.HALF(HALF)) spimsu_chk_i (
		.mclk(mclk), .rstn(rstn), .sck(spimsu_if_i.sck), .ss_n(spimsu_if_i.ss_n),
		.dev_sck_oe(spimsu_if_i.dev_sck_oe), .dev_mosi_oe(spimsu_if_i.dev_mosi_oe),
		.dev_miso_oe(spimsu_if_i.dev_miso_oe), .dev_ss_oe(spimsu_if_i.dev_ss_oe),
		.par_sck_oe(spimsu_if_i.par_sck_oe), .par_mosi_oe(spimsu_if_i.par_mosi_oe),
		.par_miso_oe(spimsu_if_i.par_miso_oe));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (mismatches == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask : rd_reg

	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask : rd_chk

	// Bounded, so a stuck flag ends as a mismatch
	task automatic poll(input logic [1:0] a, input int b, input logic v);
		logic [7:0] d;
		for (int i = 0; i < 100; i++) begin
			rd_reg(a, d);
			if (d[b] === v)
				return;
		end
		chk({7'h0, d[b]}, {7'h0, v});
	endtask : poll

	task automatic pstart(input logic [7:0] b);
		@(posedge mclk);
		tx_byte <= b;
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
	endtask : pstart

	task automatic p_wait(output logic [7:0] b);
		b = 8'hxx;
		for (int i = 0; i < 1000; i++) begin
			@(posedge mclk);
			if (rx_done === 1'b1) begin
				b = rx_byte;
				return;
			end
		end
	endtask : p_wait

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] b;
		rstn = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		gie = 1'b1;
		be_master = 1'b0;
		cpol = 1'b0;
		cpha = 1'b0;
		tx_byte = 8'h00;
		start = 1'b0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		rd_chk(REG_CTRL, CTRL_RST);
		rd_chk(REG_DIR, DIR_RST);
		rd_chk(REG_STAT, 8'h00);
		// Mode changes only while deselected, else the slave sees a false edge
		for (int m = 0; m < 4; m++) begin
			wr_reg(REG_DIR, 8'h1D);
			cpol <= m[0];
			cpha <= m[1];
			wr_reg(REG_CTRL, {3'h0, m[1], m[0], 3'h7});
			pstart(8'h3C + m[7:0]);
			wr_reg(REG_DIR, 8'h0D);
			wr_reg(REG_DATA, 8'hA5 ^ m[7:0]);
			wr_reg(REG_DATA, 8'h00);
			p_wait(b);
			chk(b, 8'hA5 ^ m[7:0]);
			poll(REG_STAT, STAT_BUSY, 1'b0);
			rd_chk(REG_DATA, 8'h3C + m[7:0]);
			chk({7'h0, irq}, 8'h01);
			rd_chk(REG_STAT, 8'h03);
			rd_chk(REG_CTRL, {3'h0, m[1], m[0], 3'h7});
			wr_reg(REG_STAT, 8'h03);
			rd_chk(REG_STAT, 8'h00);
		end
		// Raise own select first, else freeing the pin reads its own low
		wr_reg(REG_DIR, 8'h1D);
		rd_chk(REG_STAT, 8'h00);
		// Foreign master pulls select low on an undriven device
		wr_reg(REG_DIR, 8'h00);
		cpol <= 1'b0;
		cpha <= 1'b0;
		be_master <= 1'b1;
		wr_reg(REG_CTRL, 8'h07);
		pstart(8'h11);
		p_wait(b);
		poll(REG_STAT, STAT_BUSY, 1'b0);
		rd_chk(REG_CTRL, 8'h03);
		rd_chk(REG_STAT, 8'h01);
		chk({7'h0, irq}, 8'h01);
		wr_reg(REG_STAT, 8'h01);
		// Device now answers as slave
		wr_reg(REG_DIR, 8'h02);
		wr_reg(REG_DATA, 8'h96);
		pstart(8'h5A);
		p_wait(b);
		chk(b, 8'h96);
		poll(REG_STAT, STAT_BUSY, 1'b0);
		rd_chk(REG_DATA, 8'h5A);
		rd_chk(REG_STAT, 8'h01);
		// Device as slave in mode 3
		wr_reg(REG_CTRL, 8'h1B);
		cpol <= 1'b1;
		cpha <= 1'b1;
		wr_reg(REG_DATA, 8'h69);
		pstart(8'hC3);
		p_wait(b);
		chk(b, 8'h69);
		poll(REG_STAT, STAT_BUSY, 1'b0);
		rd_chk(REG_DATA, 8'hC3);
		// Software takes the master role back
		wr_reg(REG_CTRL, 8'h07);
		rd_chk(REG_CTRL, 8'h07);
		test_done();
	end
endmodule : test_spi_master_slave_unit
